/* design/msa_mdio.v */
/*
  MDIO frame engine: runs one management frame (preamble, start, opcode,
  PHY and register address, turnaround, 16 data bits) on MDC and MDIO.
  Assumes start is a one-cycle pulse from same-clock logic and mdio_in comes
  straight from the pin.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msa_regs.vh"

module msa_mdio (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire write_sel,
  input wire [4:0] phy_select,
  input wire [4:0] phy_register_index,
  input wire [15:0] wdata,
  output reg done,
  output reg [15:0] rdata,
  output reg mdc,
  output reg mdio_out,
  output reg mdio_oe,
  input wire mdio_in
);

  // Half period in clocks; cut to the divider width on purpose
  localparam integer HALF_CYC = `MSA_MDC_HALF_CYC;
  localparam [4:0] HALF_LAST = HALF_CYC[4:0] - 5'd1;

  reg sync_a;
  reg sync_b;
  reg active;
  reg wr_q;
  reg [4:0] div_cnt;
  reg [5:0] bit_cnt;
  reg [63:0] shift;
  reg [15:0] rd_shift;
  wire [63:0] frame;

  // Whole frame, first bit at the top
  assign frame = {`MSA_PREAMBLE, `MSA_FRAME_START, write_sel ? `MSA_OP_WRITE : `MSA_OP_READ,
                  phy_select, phy_register_index, `MSA_TURNAROUND, wdata};

  // Data driven after MDC falls, sampled as MDC rises; PHY sees stable data
  always @(posedge clk) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      active <= 1'b0;
      wr_q <= 1'b0;
      div_cnt <= 5'd0;
      bit_cnt <= 6'd0;
      shift <= 64'h0000_0000_0000_0000;
      rd_shift <= 16'h0000;
      done <= 1'b0;
      rdata <= 16'h0000;
      mdc <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      sync_a <= mdio_in;
      sync_b <= sync_a;
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        wr_q <= write_sel;
        div_cnt <= 5'd0;
        bit_cnt <= 6'd0;
        mdc <= 1'b0;
        mdio_out <= frame[63];
        mdio_oe <= 1'b1;
        shift <= {frame[62:0], 1'b0};
      end else if (active) begin
        if (div_cnt == HALF_LAST) begin
          div_cnt <= 5'd0;
          if (!mdc) begin
            mdc <= 1'b1;
            rd_shift <= {rd_shift[14:0], sync_b};
          end else if (bit_cnt == `MSA_FRAME_LAST) begin
            // Frame over: release the line and report
            mdc <= 1'b0;
            active <= 1'b0;
            done <= 1'b1;
            mdio_oe <= 1'b0;
            rdata <= rd_shift;
          end else begin
            mdc <= 1'b0;
            bit_cnt <= bit_cnt + 6'd1;
            mdio_out <= shift[63];
            shift <= {shift[62:0], 1'b0};
            // A read lets go of the line from the turnaround on
            mdio_oe <= wr_q || (bit_cnt < `MSA_ADDR_PHASE_LAST);
          end
        end else begin
          div_cnt <= div_cnt + 5'd1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* design/msa_regs.vh */
/*
  Constants for the MAC station address and PHY management register group:
  indirect register offsets, field positions, reset values and MDIO timing.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef MSA_REGS_VH
`define MSA_REGS_VH

// Indirect register offsets (byte addresses)
`define MSA_OFF_MAC_CTRL 16'h0000
`define MSA_OFF_ADDR_HI 16'h0004
`define MSA_OFF_ADDR_LO 16'h0008
`define MSA_OFF_MGMT_CMD 16'h0014
`define MSA_OFF_MGMT_DATA 16'h0018
`define MSA_OFF_FLOW_CTRL 16'h001C

// Field positions
`define MSA_RX_EN_BIT 2
`define MSA_CMD_PHY_MSB 15
`define MSA_CMD_PHY_LSB 11
`define MSA_CMD_IDX_MSB 10
`define MSA_CMD_IDX_LSB 6
`define MSA_CMD_WR_BIT 1
`define MSA_CMD_BUSY_BIT 0
`define MSA_FC_PT_MSB 31
`define MSA_FC_PT_LSB 16
`define MSA_FC_FCE_BIT 1
`define MSA_FC_FCB_BIT 0

// Reset values
`define MSA_RST_RX_EN 1'b0
`define MSA_RST_ADDR_HI 16'hFFFF
`define MSA_ADDR_HI_RSVD 16'hFFFF
`define MSA_RST_ADDR_LO 32'hFFFF_FFFF
`define MSA_RST_PHY 5'h0B
`define MSA_RST_IDX 5'h0B
`define MSA_RST_PT 16'h0050
`define MSA_RST_FCE 1'b1

// MDIO timing: MDC period is a least time, so the half period rounds up
`define MSA_CLK_PERIOD_NS 8
`define MSA_MDC_PERIOD_NS 400
`define MSA_MDC_HALF_CYC (((`MSA_MDC_PERIOD_NS / 2) + `MSA_CLK_PERIOD_NS - 1) / `MSA_CLK_PERIOD_NS)

// MDIO frame layout
`define MSA_FRAME_START 2'b01
`define MSA_OP_WRITE 2'b01
`define MSA_OP_READ 2'b10
`define MSA_TURNAROUND 2'b10
`define MSA_PREAMBLE 32'hFFFF_FFFF
`define MSA_FRAME_LAST 6'h3F
`define MSA_ADDR_PHASE_LAST 6'h2D

`endif

/* design/msa_top.v */
/*
  MAC station address, receive enable, flow control and PHY management
  register group, reached through an indirect address/data register port.
  Assumes the indirect port and the receive path come from logic on clk,
  and that an Ethernet PHY sits on the MDC/MDIO pins.
*/
// Overview of operation
// - Packets pass to the receiver only if the receive enable bit is 1 at their first byte.
// - Five-bit PHY select field picks one of 32 PHY addresses.
// - Five-bit index field names the register inside the chosen PHY.
// - Direction bit 1 makes a PHY write, 0 a PHY read.
// - Busy flag stays 1 during a management frame, drops when it ends.
// - Sixteen-bit data register feeds writes and holds read results.
// - Pause duration field goes into every transmitted pause frame.
`timescale 1ns/1ns
`default_nettype none
`include "msa_regs.vh"

module msa_top (
  input wire clk,
  input wire resetn,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  input wire rx_in_valid,
  input wire rx_in_sof,
  input wire [7:0] rx_in_data,
  output reg rx_out_valid,
  output reg rx_out_sof,
  output reg [7:0] rx_out_data,
  output reg rx_accept_enable,
  output reg [47:0] station_address_bits,
  output reg [15:0] pause_duration,
  output reg flow_ctrl_enable,
  output reg pause_send_req,
  input wire pause_sent,
  output wire mdc,
  output wire mdio_out,
  output wire mdio_oe,
  input wire mdio_in
);

  // Address decode, shared by the write and read paths
  function msa_hit;
    input [15:0] addr;
    input [15:0] offset;
    begin
      msa_hit = (addr == offset);
    end
  endfunction

  reg [4:0] phy_select;
  reg [4:0] phy_register_index;
  reg mgmt_write_select;
  reg mgmt_in_progress;
  reg [15:0] mgmt_data_word;
  reg mgmt_start;
  reg rx_frame_ok;
  reg [31:0] next_rdata;
  wire mgmt_done;
  wire [15:0] mgmt_rdata;
  wire wr_ctrl;
  wire wr_hi;
  wire wr_lo;
  wire wr_cmd;
  wire wr_data;
  wire wr_fc;

  // Write strobes; the port only carries indirect offsets
  assign wr_ctrl = reg_wr && msa_hit(reg_addr, `MSA_OFF_MAC_CTRL);
  assign wr_hi = reg_wr && msa_hit(reg_addr, `MSA_OFF_ADDR_HI);
  assign wr_lo = reg_wr && msa_hit(reg_addr, `MSA_OFF_ADDR_LO);
  assign wr_cmd = reg_wr && msa_hit(reg_addr, `MSA_OFF_MGMT_CMD);
  assign wr_data = reg_wr && msa_hit(reg_addr, `MSA_OFF_MGMT_DATA);
  assign wr_fc = reg_wr && msa_hit(reg_addr, `MSA_OFF_FLOW_CTRL);

  // Receive enable and station address
  always @(posedge clk) begin
    if (!resetn) begin
      rx_accept_enable <= `MSA_RST_RX_EN;
      station_address_bits <= {`MSA_RST_ADDR_HI, `MSA_RST_ADDR_LO};
    end else begin
      if (wr_ctrl) begin
        rx_accept_enable <= reg_wdata[`MSA_RX_EN_BIT];
      end
      if (wr_hi) begin
        station_address_bits[47:32] <= reg_wdata[15:0];
      end
      if (wr_lo) begin
        station_address_bits[31:0] <= reg_wdata;
      end
    end
  end

  // Flow control; a pause-done pulse loses to a host set in the same cycle
  always @(posedge clk) begin
    if (!resetn) begin
      pause_duration <= `MSA_RST_PT;
      flow_ctrl_enable <= `MSA_RST_FCE;
      pause_send_req <= 1'b0;
    end else begin
      if (wr_fc) begin
        pause_duration <= reg_wdata[`MSA_FC_PT_MSB:`MSA_FC_PT_LSB];
        flow_ctrl_enable <= reg_wdata[`MSA_FC_FCE_BIT];
      end
      if (wr_fc && reg_wdata[`MSA_FC_FCB_BIT]) begin
        pause_send_req <= 1'b1;
      end else if (pause_sent) begin
        pause_send_req <= 1'b0;
      end
    end
  end

  // Management command; a write while busy is dropped so a frame never tears
  always @(posedge clk) begin
    if (!resetn) begin
      phy_select <= `MSA_RST_PHY;
      phy_register_index <= `MSA_RST_IDX;
      mgmt_write_select <= 1'b0;
      mgmt_in_progress <= 1'b0;
      mgmt_start <= 1'b0;
    end else begin
      mgmt_start <= 1'b0;
      if (wr_cmd && !mgmt_in_progress) begin
        phy_select <= reg_wdata[`MSA_CMD_PHY_MSB:`MSA_CMD_PHY_LSB];
        phy_register_index <= reg_wdata[`MSA_CMD_IDX_MSB:`MSA_CMD_IDX_LSB];
        mgmt_write_select <= reg_wdata[`MSA_CMD_WR_BIT];
        mgmt_in_progress <= 1'b1;
        mgmt_start <= 1'b1;
      end else if (mgmt_done) begin
        mgmt_in_progress <= 1'b0;
      end
    end
  end

  // Data word; the PHY's answer wins over a host write in the same cycle
  always @(posedge clk) begin
    if (!resetn) begin
      mgmt_data_word <= 16'h0000;
    end else if (mgmt_done && !mgmt_write_select) begin
      mgmt_data_word <= mgmt_rdata;
    end else if (wr_data) begin
      mgmt_data_word <= reg_wdata[15:0];
    end
  end

  // Serial engine; it copies the data word into its frame at start, so host writes while busy do not reach the line
  msa_mdio u_mdio (
    .clk(clk),
    .resetn(resetn),
    .start(mgmt_start),
    .write_sel(mgmt_write_select),
    .phy_select(phy_select),
    .phy_register_index(phy_register_index),
    .wdata(mgmt_data_word),
    .done(mgmt_done),
    .rdata(mgmt_rdata),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .mdio_in(mdio_in)
  );

  // Read mux; unmapped offsets return zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (msa_hit(reg_addr, `MSA_OFF_MAC_CTRL)) begin
      next_rdata[`MSA_RX_EN_BIT] = rx_accept_enable;
    end else if (msa_hit(reg_addr, `MSA_OFF_ADDR_HI)) begin
      next_rdata = {`MSA_ADDR_HI_RSVD, station_address_bits[47:32]};
    end else if (msa_hit(reg_addr, `MSA_OFF_ADDR_LO)) begin
      next_rdata = station_address_bits[31:0];
    end else if (msa_hit(reg_addr, `MSA_OFF_MGMT_CMD)) begin
      next_rdata[`MSA_CMD_PHY_MSB:`MSA_CMD_PHY_LSB] = phy_select;
      next_rdata[`MSA_CMD_IDX_MSB:`MSA_CMD_IDX_LSB] = phy_register_index;
      next_rdata[`MSA_CMD_WR_BIT] = mgmt_write_select;
      next_rdata[`MSA_CMD_BUSY_BIT] = mgmt_in_progress;
    end else if (msa_hit(reg_addr, `MSA_OFF_MGMT_DATA)) begin
      next_rdata[15:0] = mgmt_data_word;
    end else if (msa_hit(reg_addr, `MSA_OFF_FLOW_CTRL)) begin
      next_rdata[`MSA_FC_PT_MSB:`MSA_FC_PT_LSB] = pause_duration;
      next_rdata[`MSA_FC_FCE_BIT] = flow_ctrl_enable;
      next_rdata[`MSA_FC_FCB_BIT] = pause_send_req;
    end
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Receive gate decided per frame at its first byte, so a frame is never cut
  always @(posedge clk) begin
    if (!resetn) begin
      rx_frame_ok <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_sof <= 1'b0;
      rx_out_data <= 8'h00;
    end else begin
      if (rx_in_valid && rx_in_sof) begin
        rx_frame_ok <= rx_accept_enable;
      end
      rx_out_valid <= rx_in_valid && (rx_in_sof ? rx_accept_enable : rx_frame_ok);
      rx_out_sof <= rx_in_valid && rx_in_sof && rx_accept_enable;
      rx_out_data <= rx_in_data;
    end
  end

endmodule

`default_nettype wire

/* dv/msa_phy_model.sv */
/* Behavioural PHY on the management bus with 32 registers.
   Assumes MDC toggles only inside frames and MDIO has a pull-up. */
`timescale 1ns/1ns
`default_nettype none
module msa_phy_model #(parameter logic [4:0] PHY_ADDR = 5'h03) (
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  logic [15:0] regs [32] = '{default: 16'h0000};
  logic [31:0] sh = '0;
  logic [13:0] hdr = '0;
  int cnt = 0;
  logic drv = 1'b0;
  logic bit_v = 1'b1;
  // Wired line: a released bus floats to the pull-up level, never the old bit
  assign mdio_in = drv ? bit_v : (mdio_oe ? mdio_out : 1'b1);
  // Sample on the rise; fields are found by bit position in the frame
  always @(posedge mdc) begin
    cnt <= (cnt == 64) ? 1 : cnt + 1;
    sh <= {sh[30:0], mdio_in};
    if (cnt == 45) hdr <= {sh[12:0], mdio_in};
    if (cnt == 63 && hdr[11:10] == 2'b01 && hdr[9:5] == PHY_ADDR)
      regs[hdr[4:0]] <= {sh[14:0], mdio_in};
  end
  // Turnaround zero then data MSB first, only when addressed on a read
  always @(negedge mdc) begin
    drv <= hdr[11:10] == 2'b10 && hdr[9:5] == PHY_ADDR && cnt >= 47 && cnt < 64;
    bit_v <= (cnt == 47) ? 1'b0 : regs[hdr[4:0]][63 - cnt];
  end
endmodule
`default_nettype wire

/* dv/msa_top_checker.sv */
/* Port checks for the register group.
   Assumes one clock and a sync active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module msa_top_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic rx_in_valid,
  input wire logic rx_in_sof,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_out_valid,
  input wire logic rx_out_sof,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_accept_enable,
  input wire logic [47:0] station_address_bits,
  input wire logic [15:0] pause_duration,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Read answer comes one cycle after each read strobe, and only then
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
  // Frame acceptance is decided at the first byte
  rx_pass_a: assert property (rx_in_valid && rx_in_sof && rx_accept_enable |=> rx_out_valid && rx_out_sof)
    else $error("enabled frame lost");
  rx_block_a: assert property (rx_in_valid && rx_in_sof && !rx_accept_enable |=> !rx_out_valid)
    else $error("disabled frame passed");
  rx_data_a: assert property (rx_out_valid |-> rx_out_data == $past(rx_in_data))
    else $error("receive byte changed");
  // Management clock shape and data held across the sampling edge
  mdc_half_a: assert property ($rose(mdc) |-> ##25 $fell(mdc)) else $error("mdc high time");
  mdio_hold_a: assert property ($rose(mdc) |-> $stable(mdio_out)) else $error("mdio moved at rise");
  // The line is only let go on a falling management clock, never while the PHY samples
  mdio_release_a: assert property ($fell(mdio_oe) |-> $fell(mdc)) else $error("mdio released off fall");
  // Register writes land on the outputs one cycle later
  pause_load_a: assert property (reg_wr && reg_addr == 16'h001C |=> pause_duration == $past(reg_wdata[31:16]))
    else $error("pause field not loaded");
  addr_low_a: assert property (reg_wr && reg_addr == 16'h0008 |=> station_address_bits[31:0] == $past(reg_wdata))
    else $error("low address not loaded");
endmodule
bind msa_top msa_top_checker i_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .rx_in_valid(rx_in_valid), .rx_in_sof(rx_in_sof),
  .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid), .rx_out_sof(rx_out_sof), .rx_out_data(rx_out_data),
  .rx_accept_enable(rx_accept_enable), .station_address_bits(station_address_bits),
  .pause_duration(pause_duration), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
`default_nettype wire

/* dv/msa_top_test.sv */
/* Bench for the station address, receive gate and PHY management block.
   Assumes msa_phy_model on the MDIO pins and a 125 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module msa_top_test;
  localparam logic [4:0] PA = 5'h03;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid, rx_in_valid, rx_in_sof, rx_out_valid, rx_out_sof;
  logic rx_accept_enable, flow_ctrl_enable, pause_send_req, pause_sent, mdc, mdio_out, mdio_oe, mdio_in;
  logic [15:0] reg_addr, pause_duration, k, pm [32];
  logic [15:0] al [6] = '{16'h0000, 16'h0004, 16'h0008, 16'h0018, 16'h001C, 16'h0024};
  logic [31:0] reg_wdata, reg_rdata, d, v, m [int];
  logic [7:0] rx_in_data, rx_out_data, expq [$], got [$];
  logic [47:0] station_address_bits;
  int num_errors = 0, n_checks = 0, seed = 32'hc204_cafc;
  msa_top i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_in_valid(rx_in_valid),
    .rx_in_sof(rx_in_sof), .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid), .rx_out_sof(rx_out_sof),
    .rx_out_data(rx_out_data), .rx_accept_enable(rx_accept_enable), .station_address_bits(station_address_bits),
    .pause_duration(pause_duration), .flow_ctrl_enable(flow_ctrl_enable), .pause_send_req(pause_send_req),
    .pause_sent(pause_sent), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in));
  msa_phy_model #(.PHY_ADDR(PA)) i_phy (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in));
  // Clock and receive monitor
  always #4 clk = ~clk;
  always @(posedge clk) if (rx_out_valid === 1'b1) got.push_back(rx_out_data);
  task automatic chk(string n, logic [47:0] s, logic [47:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write strobe; the reference image follows each write
  task automatic wr(logic [15:0] a, logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      16'h0000: m[a] = w & 32'h0000_0004;
      16'h0004: m[a] = {16'hFFFF, w[15:0]};
      16'h0008: m[a] = w;
      16'h0018: m[a] = {16'h0000, w[15:0]};
      16'h001C: m[a] = {w[31:16], 14'h0000, w[1], m[a][0] | w[0]};
      default: ;
    endcase
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rvalid", reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask
  // Full management transaction; a second command while busy must be ignored
  task automatic mgmt(logic [4:0] p, logic [4:0] r, logic w, logic [15:0] x);
    int n;
    n = 0;
    if (w) wr(16'h0018, {16'h0000, x});
    wr(16'h0014, {16'h0000, p, r, 4'h0, w, 1'b0});
    m[16'h0014] = {16'h0000, p, r, 4'h0, w, 1'b0};
    if (w && p == PA) pm[r] = x;
    if (!w) m[16'h0018] = (p == PA) ? {16'h0000, pm[r]} : 32'h0000_FFFF;
    rd(16'h0014);
    chk("busy set", d[0], 1'b1);
    wr(16'h0014, 32'h0000_0002);
    while (d[0] === 1'b1 && n < 2000) begin
      rd(16'h0014);
      n++;
    end
    chk("busy span", n > 1550 && n < 1650, 1'b1);
    chk("command", d, m[16'h0014]);
    rd(16'h0018);
    chk("mgmt data", d, m[16'h0018]);
  endtask
  task automatic frame(int len);
    logic on;
    logic [7:0] b;
    on = m[16'h0000][2];
    for (int i = 0; i < len; i++) begin
      b = $random(seed);
      if (on) expq.push_back(b);
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in_sof <= (i == 0);
      rx_in_data <= b;
    end
    @(posedge clk);
    rx_in_valid <= 1'b0;
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the run needs about 13k cycles, so 25k means a hang
  initial begin
    #200_000;
    num_errors++;
    complete_run;
  end
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {reg_wr, reg_rd, rx_in_valid, rx_in_sof, pause_sent, reg_addr, reg_wdata, rx_in_data} = '0;
    pm = '{default: 16'h0000};
    m = '{16'h0000: 32'h0000_0000, 16'h0004: 32'hFFFF_FFFF, 16'h0008: 32'hFFFF_FFFF, 16'h0014: 32'h0000_5AC0,
      16'h0018: 32'h0000_0000, 16'h001C: 32'h0050_0002, 16'h0024: 32'h0000_0000, default: 32'h0000_0000};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("reset outs", {rx_accept_enable, flow_ctrl_enable, pause_send_req, pause_duration}, 19'h2_0050);
    foreach (m[a]) begin
      rd(a[15:0]);
      chk("reset reg", d, m[a]);
    end
    // Random register traffic, bit 0 of flow control kept clear here
    repeat (16) begin
      k = al[{$random(seed)} % 6];
      v = $random(seed) & 32'hFFFF_FFFE;
      wr(k, v);
      rd(k);
      chk("reg rw", d, m[k]);
    end
    chk("station", station_address_bits, {m[16'h0004][15:0], m[16'h0008]});
    chk("pause", {rx_accept_enable, flow_ctrl_enable, pause_duration},
      {m[16'h0000][2], m[16'h001C][1], m[16'h001C][31:16]});
    wr(16'h0000, 32'h0000_0000);
    frame(4);
    wr(16'h0000, 32'h0000_0004);
    frame(5);
    frame(3);
    wr(16'h0000, 32'h0000_0000);
    frame(3);
    repeat (3) @(posedge clk);
    chk("rx count", got.size(), expq.size());
    foreach (got[i]) chk("rx byte", got[i], expq[i]);
    wr(16'h001C, 32'h0050_0003);
    #1 chk("pause req", pause_send_req, 1'b1);
    @(posedge clk);
    pause_sent <= 1'b1;
    @(posedge clk);
    pause_sent <= 1'b0;
    #1 chk("pause done", pause_send_req, 1'b0);
    m[16'h001C][0] = 1'b0;
    v = $random(seed);
    mgmt(PA, 5'h11, 1'b1, v[15:0]);
    mgmt(5'h1C, 5'h11, 1'b1, ~v[15:0]);
    mgmt(PA, 5'h11, 1'b0, 16'h0000);
    mgmt(5'h1C, 5'h02, 1'b0, 16'h0000);
    complete_run;
  end
endmodule
`default_nettype wire
